// ==== bench/rtc_host_model.sv ====
// host-side serial master model for the register link
module rtc_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h55 // arbitrary value
) (
	// link pins
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// quarter of the 160 ns link period
	localparam time QTR = 40ns;

	// link clock stands high between frames
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic put_bit(input logic b);
		#QTR sda_drv = b;
		#QTR scl = 1'b1;
		#(2*QTR) scl = 1'b0;
	endtask

	// data changes a quarter after scl falls, past the slave's release
	task automatic get_bit(output logic b);
		#QTR sda_drv = 1'b1;
		#QTR scl = 1'b1;
		#QTR b = sda;
		#QTR scl = 1'b0;
	endtask

	task automatic start_cond;
		#QTR sda_drv = 1'b1;
		#QTR scl = 1'b1;
		#QTR sda_drv = 1'b0;
		#QTR scl = 1'b0;
	endtask

	task automatic stop_cond;
		#QTR sda_drv = 1'b0;
		#QTR scl = 1'b1;
		#QTR sda_drv = 1'b1;
		#(2*QTR);
	endtask

	task automatic put_byte(input logic [7:0] d, inout logic ok);
		logic a;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(a);
		ok = ok & ~a;
	endtask

	// last byte of a read: the master answers with a nack
	task automatic get_byte(output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(1'b1);
	endtask

	// ok is high only when every byte was acknowledged
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		output logic ok);
		ok = 1'b1;
		start_cond();
		put_byte({DEV_ADDR, 1'b0}, ok);
		put_byte(a, ok);
		put_byte(d, ok);
		stop_cond();
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic ok;
		ok = 1'b1;
		start_cond();
		put_byte({DEV_ADDR, 1'b0}, ok);
		put_byte(a, ok);
		start_cond();
		put_byte({DEV_ADDR, 1'b1}, ok);
		get_byte(d);
		stop_cond();
	endtask
endmodule // rtc_host_model

// ==== bench/rtc_trim_charge_unlock_tb.sv ====
// self-checking bench for the trim, charge and unlock block
module rtc_trim_charge_unlock_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rtc_pkg::*;
	// short recovery so the return from backup stays cheap
	localparam int RECOVER = 200;
	logic       clk;
	logic       rst_n;
	logic       scl;
	logic       sda_drv;
	logic       sda_o;
	logic       sda_oe;
	logic       backup_i;
	logic [7:0] year_bcd;
	logic [7:0] month_bcd;
	logic       irq_o;
	logic       switch2_o;
	logic       bypass_o;
	logic       charge_on_o;
	logic       time_ready_o;
	logic [4:0] month_days_o;
	// open-drain line with pull-up
	wire        sda = sda_drv & ~(sda_oe & ~sda_o);
	int         num_errors = 0;
	int         n_tests = 0;
	logic [7:0] yr_t [6] = '{8'h24, 8'h23, 8'h00, 8'h10, 8'h23, 8'h23};
	logic [7:0] mo_t [6] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h04, 8'h12};
	logic [4:0] dy_t [6] = '{5'h1d, 5'h1c, 5'h1d, 5'h1c, 5'h1e, 5'h1f};

	rtc_trim_charge_unlock #(
		.DEV_ADDR       (7'h55),
		.RECOVER_CYCLES (RECOVER)
	) uut (
		.clk          (clk),
		.rst_n        (rst_n),
		.scl_i        (scl),
		.sda_i        (sda),
		.sda_o        (sda_o),
		.sda_oe       (sda_oe),
		.backup_i     (backup_i),
		.year_bcd     (year_bcd),
		.month_bcd    (month_bcd),
		.irq_o        (irq_o),
		.switch2_o    (switch2_o),
		.bypass_o     (bypass_o),
		.charge_on_o  (charge_on_o),
		.time_ready_o (time_ready_o),
		.month_days_o (month_days_o)
	);

	rtc_host_model #(
		.DEV_ADDR (7'h55)
	) host (
		.scl     (scl),
		.sda_drv (sda_drv),
		.sda     (sda)
	);

	initial clk = 1'b0;
	always #4 clk = ~clk;

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic pin(input string what, input logic seen, input logic exp);
		check(what, {7'h00, seen}, {7'h00, exp});
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d,
		input logic ack);
		logic ok;
		settle(1);
		host.wr(a, d, ok);
		pin("ack", ok, ack);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		settle(1);
		host.rd(a, d);
		check($sformatf("reg %h", a), d, exp);
	endtask

	// the key pair opens exactly one protected write
	task automatic unlock;
		wreg(REG_KEY1, KEY1_VAL, 1'b1);
		wreg(REG_KEY2, KEY2_VAL, 1'b1);
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		rst_n = 1'b0;
		backup_i = 1'b0;
		year_bcd = 8'h23;
		month_bcd = 8'h01;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		settle(10);
		pin("irq", irq_o, 1'b1);
		pin("switch", switch2_o, 1'b0);
		pin("bypass", bypass_o, 1'b0);
		pin("charge", charge_on_o, 1'b0);
		pin("ready", time_ready_o, 1'b0);
		rchk(REG_CAL, CAL_RST);
		rchk(REG_TCH, TCH_RST);
		rchk(REG_CHARGER_CONFIGURATION, CHARGER_CONFIGURATION_RST);
		rchk(REG_SFR, SFR_RST);
		pin("ready", time_ready_o, 1'b1);
		wreg(REG_CAL, 8'h3f, 1'b1);
		rchk(REG_CAL, 8'h3f);
		pin("irq", irq_o, 1'b0);
		wreg(REG_CAL, 8'h80, 1'b1);
		settle(3);
		pin("irq", irq_o, 1'b1);
		wreg(REG_TCH, 8'h20, 1'b1);
		for (int c = 0; c < 16; c++)
		begin
			wreg(REG_CHARGER_CONFIGURATION, {4'h4, c[3:0]}, 1'b1);
			settle(3);
			pin("bypass", bypass_o, 1'b1);
			pin("switch", switch2_o, 1'b1);
			pin("charge", charge_on_o, c == 5);
		end
		wreg(REG_TCH, 8'h00, 1'b1);
		settle(3);
		pin("charge", charge_on_o, 1'b0);
		wreg(REG_CHARGER_CONFIGURATION, 8'h05, 1'b1);
		settle(3);
		pin("bypass", bypass_o, 1'b0);
		wreg(REG_SFR, 8'h01, 1'b1);
		rchk(REG_SFR, 8'h00);
		wreg(REG_KEY1, KEY1_VAL, 1'b1);
		rchk(REG_KEY1, 8'h00);
		wreg(REG_KEY2, KEY2_VAL, 1'b1);
		rchk(REG_KEY2, 8'h00);
		wreg(REG_CAL, 8'h80, 1'b1);
		wreg(REG_SFR, 8'h01, 1'b1);
		rchk(REG_SFR, 8'h00);
		unlock();
		wreg(REG_SFR, 8'h01, 1'b1);
		rchk(REG_SFR, 8'h01);
		wreg(REG_SFR, 8'h00, 1'b1);
		rchk(REG_SFR, 8'h01);
		wreg(REG_KEY1, KEY1_VAL, 1'b1);
		wreg(REG_KEY2, 8'hc6, 1'b1);
		wreg(REG_SFR, 8'h00, 1'b1);
		rchk(REG_SFR, 8'h01);
		wreg(REG_KEY2, KEY2_VAL, 1'b1);
		wreg(REG_KEY1, KEY1_VAL, 1'b1);
		wreg(REG_SFR, 8'h00, 1'b1);
		rchk(REG_SFR, 8'h01);
		unlock();
		wreg(REG_SFR, 8'h00, 1'b1);
		rchk(REG_SFR, 8'h00);
		// test wave on; prescaler still in the low half of its second
		wreg(REG_CAL, 8'hc0, 1'b1);
		unlock();
		wreg(REG_SFR, 8'h01, 1'b1);
		settle(3);
		pin("irq", irq_o, 1'b1);
		wreg(REG_CAL, 8'h80, 1'b1);
		settle(3);
		pin("irq", irq_o, 1'b1);
		for (int i = 0; i < 6; i++)
		begin
			year_bcd = yr_t[i];
			month_bcd = mo_t[i];
			settle(3);
			check("days", {3'h0, month_days_o}, {3'h0, dy_t[i]});
		end
		backup_i = 1'b1;
		settle(5);
		wreg(REG_CAL, 8'h00, 1'b0);
		pin("ready", time_ready_o, 1'b0);
		backup_i = 1'b0;
		settle(RECOVER - 20);
		pin("ready", time_ready_o, 1'b0);
		settle(30);
		pin("ready", time_ready_o, 1'b1);
		rchk(REG_CAL, 8'h80);
		wrap_up();
	end

	// about three times the expected length of the sequence
	initial
	begin
		#800us;
		num_errors++;
		$display("ERROR watchdog expected finish seen timeout");
		wrap_up();
	end
endmodule // rtc_trim_charge_unlock_tb

// ==== hw/rtc_i2c_slave.sv ====
// serial register slave: byte framing, pointer, write strobe, read shift
module rtc_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h55 // arbitrary value
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       enable,
	// pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_oe,
	// register side
	output logic [7:0]      ptr,
	input  wire logic [7:0] rd_data,
	output logic            wr_en,
	output logic [7:0]      wr_addr,
	output logic [7:0]      wr_data
);
	import rtc_pkg::*;

	logic        scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
	rtc_i2c_st_t st_r, st_nxt;
	logic [2:0]  bit_r, bit_nxt;
	logic [7:0]  sh_r, sh_nxt, ptr_r, ptr_nxt, wa_r, wa_nxt, wd_r, wd_nxt;
	logic        addr_ph_r, addr_ph_nxt, ptr_ph_r, ptr_ph_nxt;
	logic        rd_r, rd_nxt, got_r, got_nxt, oe_r, oe_nxt, we_r, we_nxt;
	logic        scl_rise, scl_fall, start_c, stop_c;

	assign scl_rise = scl_s_r & ~scl_d_r;
	assign scl_fall = ~scl_s_r & scl_d_r;
	assign start_c  = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign stop_c   = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	always_comb
	begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		ptr_nxt = ptr_r;
		wa_nxt = wa_r;
		wd_nxt = wd_r;
		addr_ph_nxt = addr_ph_r;
		ptr_ph_nxt = ptr_ph_r;
		rd_nxt = rd_r;
		got_nxt = got_r;
		oe_nxt = oe_r;
		we_nxt = 1'b0;
		if (!enable)
		begin
			// on backup the pins are ignored entirely
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end
		else if (start_c)
		begin
			st_nxt = ST_RX;
			bit_nxt = 3'h0;
			addr_ph_nxt = 1'b1;
			got_nxt = 1'b0;
			oe_nxt = 1'b0;
		end
		else if (stop_c)
		begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end
		else
		begin
			case (st_r)
				ST_RX:
				begin
					if (scl_rise)
					begin
						sh_nxt = {sh_r[6:0], sda_s_r};
						bit_nxt = bit_r + 3'h1;
						got_nxt = (bit_r == 3'h7);
					end
					else if (scl_fall && got_r)
					begin
						got_nxt = 1'b0;
						oe_nxt = 1'b1;
						st_nxt = ST_ACK;
						if (addr_ph_r)
						begin
							addr_ph_nxt = 1'b0;
							rd_nxt = sh_r[0];
							ptr_ph_nxt = ~sh_r[0];
							if (sh_r[7:1] != DEV_ADDR)
							begin
								oe_nxt = 1'b0;
								st_nxt = ST_IDLE;
							end
						end
						else if (ptr_ph_r)
						begin
							ptr_ph_nxt = 1'b0;
							ptr_nxt = sh_r;
						end
						else
						begin
							we_nxt = 1'b1;
							wa_nxt = ptr_r;
							wd_nxt = sh_r;
							ptr_nxt = ptr_r + 8'h01;
						end
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						bit_nxt = 3'h0;
						if (rd_r)
						begin
							sh_nxt = rd_data;
							ptr_nxt = ptr_r + 8'h01;
							oe_nxt = ~rd_data[7];
							st_nxt = ST_TX;
						end
						else
						begin
							oe_nxt = 1'b0;
							st_nxt = ST_RX;
						end
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						if (bit_r == 3'h7)
						begin
							oe_nxt = 1'b0;
							st_nxt = ST_TXACK;
						end
						else
						begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_nxt = ~sh_r[6];
							bit_nxt = bit_r + 3'h1;
						end
					end
				end
				ST_TXACK:
				begin
					// master ack means another byte; nack waits for stop
					if (scl_rise)
						st_nxt = sda_s_r ? ST_IDLE : ST_ACK;
				end
				default:
					st_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'b111;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'b111;
			st_r <= ST_IDLE;
			bit_r <= 3'h0;
			sh_r <= 8'h00;
			ptr_r <= 8'h00;
			wa_r <= 8'h00;
			wd_r <= 8'h00;
			addr_ph_r <= 1'b0;
			ptr_ph_r <= 1'b0;
			rd_r <= 1'b0;
			got_r <= 1'b0;
			oe_r <= 1'b0;
			we_r <= 1'b0;
		end
		else
		begin
			{scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			ptr_r <= ptr_nxt;
			wa_r <= wa_nxt;
			wd_r <= wd_nxt;
			addr_ph_r <= addr_ph_nxt;
			ptr_ph_r <= ptr_ph_nxt;
			rd_r <= rd_nxt;
			got_r <= got_nxt;
			oe_r <= oe_nxt;
			we_r <= we_nxt;
		end
	end

	assign sda_oe  = oe_r;
	assign ptr     = ptr_r;
	assign wr_en   = we_r;
	assign wr_addr = wa_r;
	assign wr_data = wd_r;
endmodule // rtc_i2c_slave

// ==== hw/rtc_pkg.sv ====
// shared constants and types for the rtc trim, charge and unlock block
package rtc_pkg;
	// register offsets
	localparam logic [7:0] REG_CAL   = 8'h07;
	localparam logic [7:0] REG_TCH   = 8'h08;
	localparam logic [7:0] REG_CHARGER_CONFIGURATION  = 8'h09;
	localparam logic [7:0] REG_KEY1  = 8'h20;
	localparam logic [7:0] REG_KEY2  = 8'h21;
	localparam logic [7:0] REG_SFR   = 8'h22;
	// reset values
	localparam logic [7:0] CAL_RST   = 8'h80;
	localparam logic [7:0] TCH_RST   = 8'h90;
	localparam logic [7:0] CHARGER_CONFIGURATION_RST  = 8'haa;
	localparam logic [7:0] SFR_RST   = 8'h00;
	// key values and the charger enable code
	localparam logic [7:0] KEY1_VAL  = 8'h5e;
	localparam logic [7:0] KEY2_VAL  = 8'hc7;
	localparam logic [3:0] CHG_CODE  = 4'h5;
	// field positions
	localparam int CAL_OUT_BIT  = 7;
	localparam int CAL_FT_BIT   = 6;
	localparam int CAL_SIGN_BIT = 5;
	localparam int TCH_SW2_BIT  = 5;
	localparam int CHARGER_CONFIGURATION_BYP_BIT = 6;
	localparam int SFR_FTF_BIT  = 0;
	// timing
	localparam int CLK_HZ       = 125_000_000;
	localparam int OSC_HZ       = 32_768;
	localparam int SEC_PER_MIN  = 60;
	localparam int MIN_TICKS    = OSC_HZ * SEC_PER_MIN;
	localparam int SLOW_SPAN    = 491_520;
	localparam int FAST_SPAN    = 245_760;
	localparam int SLOW_STEP    = MIN_TICKS / SLOW_SPAN;
	localparam int FAST_STEP    = MIN_TICKS / FAST_SPAN;
	localparam int SQ512_HALF   = OSC_HZ / 512 / 2;
	localparam int RECOVER_S    = 1;
	localparam int RECOVER_CYC  = RECOVER_S * CLK_HZ;
	// serial slave states, gray along the byte path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RX    = 3'b001,
		ST_ACK   = 3'b011,
		ST_TX    = 3'b010,
		ST_TXACK = 3'b110
	} rtc_i2c_st_t;
	// unlock progress
	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_KEY1 = 2'b01,
		LK_OPEN = 2'b11
	} rtc_lock_st_t;
endpackage

// ==== hw/rtc_trim_charge_unlock.sv ====
// registers, trimmed timebase, test output, charger and unlock logic
//Contract
// - output level bit drives pin when test off
// - test enable puts square wave on pin
// - sign bit zero slows, one speeds
// - trim N counts per minute span
// - switch two follows its bit; charge needs all
// - bypass transistor follows its bit
// - charger active only at code five
// - first key reads zero, key 5e
// - second key reads zero, key c7
// - protected write needs both keys in order
// - keys repeated before every protected write
// - rate select clear 512 Hz, set 1 Hz
// - 512 Hz wave ignores trim
// - 1 Hz wave follows trim
// - every year divisible by four leaps
// - backup supply silences serial, time continues
// - time valid one second after main returns
// - calibration register resets to 80
// - charger configuration resets to aa
module rtc_trim_charge_unlock
	import rtc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR       = 7'h55, // arbitrary value
	parameter int         RECOVER_CYCLES = rtc_pkg::RECOVER_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// serial pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// supply and date inputs
	input  wire logic       backup_i,
	input  wire logic [7:0] year_bcd,
	input  wire logic [7:0] month_bcd,
	// pins and status
	output logic            irq_o,
	output logic            switch2_o,
	output logic            bypass_o,
	output logic            charge_on_o,
	output logic            time_ready_o,
	output logic [4:0]      month_days_o
);
	import rtc_pkg::*;

	// recovery counter is 27 bits wide
	if (RECOVER_CYCLES < 1 || RECOVER_CYCLES >= (1 << 27))
	begin : g_bad_recover
		$error("RECOVER_CYCLES out of range");
	end

	logic        rst_m_r, rst_core_n;
	logic        bk_m_r, bk_s_r;
	logic        wr_en, oe_w;
	logic [7:0]  wr_addr, wr_data, ptr, rd_data;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{rst_m_r, rst_core_n} <= 2'b00;
		else
			{rst_m_r, rst_core_n} <= {1'b1, rst_m_r};
	end

	always_ff @(posedge clk or negedge rst_core_n)
	begin
		if (!rst_core_n)
			{bk_m_r, bk_s_r} <= 2'b00;
		else
			{bk_m_r, bk_s_r} <= {backup_i, bk_m_r};
	end

	rtc_i2c_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_slave (
		.clk     (clk),
		.rst_n   (rst_core_n),
		.enable  (~bk_s_r),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.sda_oe  (oe_w),
		.ptr     (ptr),
		.rd_data (rd_data),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data)
	);

	// register file and unlock sequence
	logic [7:0]   cal_r, cal_nxt, tch_r, tch_nxt, charger_configuration_r, charger_configuration_nxt;
	logic [7:0]   sfr_r, sfr_nxt;
	rtc_lock_st_t lk_r, lk_nxt;

	always_comb
	begin
		cal_nxt = cal_r;
		tch_nxt = tch_r;
		charger_configuration_nxt = charger_configuration_r;
		sfr_nxt = sfr_r;
		lk_nxt = lk_r;
		if (wr_en)
		begin
			// any write that is not the next key drops progress
			lk_nxt = LK_IDLE;
			case (wr_addr)
				REG_CAL:  cal_nxt = wr_data;
				REG_TCH:  tch_nxt = wr_data;
				REG_CHARGER_CONFIGURATION: charger_configuration_nxt = wr_data;
				REG_KEY1:
					if (wr_data == KEY1_VAL)
						lk_nxt = LK_KEY1;
				REG_KEY2:
					if (lk_r == LK_KEY1 && wr_data == KEY2_VAL)
						lk_nxt = LK_OPEN;
				REG_SFR:
					// unlock is spent here either way
					if (lk_r == LK_OPEN)
						sfr_nxt = wr_data;
				default: lk_nxt = LK_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			cal_r <= CAL_RST;
			tch_r <= TCH_RST;
			charger_configuration_r <= CHARGER_CONFIGURATION_RST;
			sfr_r <= SFR_RST;
			lk_r <= LK_IDLE;
		end
		else
		begin
			cal_r <= cal_nxt;
			tch_r <= tch_nxt;
			charger_configuration_r <= charger_configuration_nxt;
			sfr_r <= sfr_nxt;
			lk_r <= lk_nxt;
		end
	end

	// key registers read as zero; unmapped addresses too
	always_comb
	begin
		case (ptr)
			REG_CAL:  rd_data = cal_r;
			REG_TCH:  rd_data = tch_r;
			REG_CHARGER_CONFIGURATION: rd_data = charger_configuration_r;
			REG_SFR:  rd_data = sfr_r;
			default:  rd_data = 8'h00;
		endcase
	end

	// oscillator tick from a phase accumulator, then trimmed prescaler
	logic [26:0] acc_r, acc_nxt;
	logic [27:0] acc_sum;
	logic        tick;
	logic [14:0] div_r, div_nxt;
	logic [15:0] div_sum;
	logic [5:0]  sec_r, sec_nxt;
	logic [7:0]  adj_r, adj_nxt;
	logic        fast_r, fast_nxt;
	logic [4:0]  raw_r, raw_nxt;
	logic        sq512_r, sq512_nxt;
	logic [4:0]  trim_n;

	assign acc_sum = {1'b0, acc_r} + 28'(OSC_HZ);
	assign tick    = acc_sum >= 28'(CLK_HZ);
	assign trim_n  = cal_r[4:0];

	always_comb
	begin
		acc_nxt = tick ? 27'(acc_sum - 28'(CLK_HZ)) : acc_sum[26:0];
		div_nxt = div_r;
		sec_nxt = sec_r;
		adj_nxt = adj_r;
		fast_nxt = fast_r;
		raw_nxt = raw_r;
		sq512_nxt = sq512_r;
		div_sum = {1'b0, div_r} + 16'h0001;
		if (tick)
		begin
			// untrimmed divider for the fast test wave
			if (raw_r == 5'(SQ512_HALF - 1))
			begin
				raw_nxt = 5'h00;
				sq512_nxt = ~sq512_r;
			end
			else
				raw_nxt = raw_r + 5'h01;
			if (adj_r != 8'h00 && fast_r)
				div_sum = {1'b0, div_r} + 16'h0002;
			if (adj_r != 8'h00)
				adj_nxt = adj_r - 8'h01;
			// slowing swallows the tick entirely
			if (!(adj_r != 8'h00 && !fast_r))
			begin
				div_nxt = div_sum[14:0];
				if (div_sum[15])
				begin
					if (sec_r == 6'(SEC_PER_MIN - 1))
					begin
						sec_nxt = 6'h00;
						fast_nxt = cal_r[CAL_SIGN_BIT];
						adj_nxt = cal_r[CAL_SIGN_BIT]
							? 8'({3'b000, trim_n} * 8'(FAST_STEP))
							: 8'({3'b000, trim_n} * 8'(SLOW_STEP));
					end
					else
						sec_nxt = sec_r + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			acc_r <= 27'h0;
			div_r <= 15'h0;
			sec_r <= 6'h00;
			adj_r <= 8'h00;
			fast_r <= 1'b0;
			raw_r <= 5'h00;
			sq512_r <= 1'b0;
		end
		else
		begin
			// the timebase never stops on backup
			acc_r <= acc_nxt;
			div_r <= div_nxt;
			sec_r <= sec_nxt;
			adj_r <= adj_nxt;
			fast_r <= fast_nxt;
			raw_r <= raw_nxt;
			sq512_r <= sq512_nxt;
		end
	end

	// outputs, recovery timer and month length
	logic        irq_nxt, charge_nxt, ready_nxt, leap;
	logic [26:0] rec_r, rec_nxt;
	logic [4:0]  days_nxt;

	assign leap = year_bcd[4] ? (year_bcd[3:0] == 4'h2 || year_bcd[3:0] == 4'h6)
		: (year_bcd[3:0] == 4'h0 || year_bcd[3:0] == 4'h4
		|| year_bcd[3:0] == 4'h8);

	always_comb
	begin
		if (cal_r[CAL_FT_BIT])
			irq_nxt = sfr_r[SFR_FTF_BIT] ? ~div_r[14] : sq512_r;
		else
			irq_nxt = cal_r[CAL_OUT_BIT];
		charge_nxt = tch_r[TCH_SW2_BIT] && charger_configuration_r[3:0] == CHG_CODE;
		rec_nxt = rec_r;
		ready_nxt = 1'b0;
		if (bk_s_r)
			rec_nxt = 27'h0;
		else if (rec_r != 27'(RECOVER_CYCLES))
			rec_nxt = rec_r + 27'h1;
		else
			ready_nxt = 1'b1;
		case (month_bcd)
			8'h02:   days_nxt = leap ? 5'd29 : 5'd28;
			8'h04, 8'h06, 8'h09, 8'h11:
				days_nxt = 5'd30;
			default: days_nxt = 5'd31;
		endcase
	end

	always_ff @(posedge clk or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			irq_o <= 1'b1;
			switch2_o <= 1'b0;
			bypass_o <= 1'b0;
			charge_on_o <= 1'b0;
			rec_r <= 27'h0;
			time_ready_o <= 1'b0;
			month_days_o <= 5'd31;
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
		end
		else
		begin
			irq_o <= irq_nxt;
			switch2_o <= tch_r[TCH_SW2_BIT];
			bypass_o <= charger_configuration_r[CHARGER_CONFIGURATION_BYP_BIT];
			charge_on_o <= charge_nxt;
			rec_r <= rec_nxt;
			time_ready_o <= ready_nxt;
			month_days_o <= days_nxt;
			sda_o <= 1'b0;
			sda_oe <= oe_w;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_core_n);

	AST_IRQ_LEVEL: assert property (!cal_r[CAL_FT_BIT] |=> irq_o == $past(cal_r[CAL_OUT_BIT])) else $error("pin level wrong");
	AST_IRQ_512: assert property (cal_r[CAL_FT_BIT] && !sfr_r[SFR_FTF_BIT] |=> irq_o == $past(sq512_r)) else $error("512 Hz wave wrong");
	AST_IRQ_1HZ: assert property (cal_r[CAL_FT_BIT] && sfr_r[SFR_FTF_BIT] |=> irq_o == !$past(div_r[14])) else $error("1 Hz wave wrong");
	AST_SLOW_SKIP: assert property (tick && adj_r != 8'h00 && !fast_r |=> div_r == $past(div_r) && adj_r == $past(adj_r) - 8'h01) else $error("slow trim wrong");
	AST_FAST_STEP: assert property (tick && adj_r != 8'h00 && fast_r |=> div_r == 15'($past(div_r) + 15'h2)) else $error("fast trim wrong");
	AST_CHARGE: assert property (##1 charge_on_o == ($past(tch_r[TCH_SW2_BIT]) && $past(charger_configuration_r[3:0]) == CHG_CODE)) else $error("charger state wrong");
	AST_BYPASS: assert property (##1 bypass_o == $past(charger_configuration_r[CHARGER_CONFIGURATION_BYP_BIT])) else $error("bypass wrong");
	AST_KEY_READ: assert property ((ptr == REG_KEY1 || ptr == REG_KEY2) |-> rd_data == 8'h00) else $error("key read nonzero");
	AST_LOCKED: assert property (wr_en && wr_addr == REG_SFR && lk_r != LK_OPEN |=> sfr_r == $past(sfr_r)) else $error("locked write taken");
	AST_ONE_SHOT: assert property (wr_en && wr_addr == REG_SFR |=> lk_r == LK_IDLE ##1 lk_r != LK_OPEN) else $error("unlock not consumed");
	AST_BACKUP: assert property (bk_s_r |=> !oe_w ##1 !sda_oe && !time_ready_o) else $error("active on backup");
	AST_RESET: assert property ($rose(rst_core_n) |-> cal_r == CAL_RST && charger_configuration_r == CHARGER_CONFIGURATION_RST) else $error("reset value wrong");
	AST_LEAP: assert property (month_bcd == 8'h02 && year_bcd == 8'h24 |=> month_days_o == 5'd29) else $error("leap year wrong");

	COV_UNLOCK: cover property (wr_en && wr_addr == REG_SFR && lk_r == LK_OPEN);
	COV_1HZ: cover property (cal_r[CAL_FT_BIT] && sfr_r[SFR_FTF_BIT] ##1 $rose(irq_o));
	COV_CHARGE: cover property ($rose(charge_on_o));
	COV_SKIP: cover property (tick && adj_r != 8'h00 && !fast_r);
endmodule // rtc_trim_charge_unlock
